// ### mdm_mgmt_host.sv
// management (mdio) master with apb register file and interrupt
// Summary of operation
// - command taken anytime, applied between frames only
// - five-bit target phy field, bits 28-24
// - five-bit phy register index, bits 20-16
// - access kind 01 writes, 10 reads
// - writing initiate bit 11 launches transaction
// - initiate bit clears itself after write
// - ready bit 7, reads one after reset
// - sixteen-bit write payload, upper half zero
// - read data from phy lands in result
// - status bit 0 set on management event
// - software writes one sets, zero clears status
// - port disabled while clock divide is zero
// - mdc equals host clock over 2(div+1)
// - pending reads status and enable together
// - clear bit clears status, self-returns zero
//
// Added by the designer: the APB interface to the registers.
`timescale 1ns/1ps
module mdm_mgmt_host #(
  parameter int ADDR_W = 12
) (
  input wire logic clk_sys_in,
  input wire logic rst_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [ADDR_W-1:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  output logic mdc_out,
  output logic mdio_out,
  output logic mdio_oe_n_out,
  input wire logic mdio_in,
  output logic irq_out
);
  // bus state
  logic pready_ff; // answer strobe
  logic pslverr_ff; // unmapped access flag
  logic [31:0] prdata_ff; // registered read data
  logic [31:0] rdata; // read mux
  logic mapped; // address hits a register
  // software registers
  logic [5:0] div_ff; // clock divide field
  logic port_on_ff; // port enable bit
  logic [4:0] phy_ff; // target_phy_field
  logic [4:0] reg_ff; // phy_reg_index
  logic [1:0] kind_ff; // access_kind
  logic start_ff; // initiate, one cycle only
  logic ready_ff; // ready bit
  logic [15:0] wpay_ff; // mgmt_write_payload
  logic [15:0] rres_ff; // mgmt_read_result
  logic ist_ff; // mgmt_irq_status
  logic ien_ff; // mgmt_irq_enable
  logic iclr_ff; // mgmt_irq_clear, self clearing
  logic irq_ff; // interrupt line
  // engine
  mdm_pkg::mdm_state_t state_ff; // engine state
  logic [5:0] div_act_ff; // divider in use for this frame
  logic [5:0] cnt_ff; // half period counter
  logic mdc_ff; // management clock
  logic [63:0] shift_ff; // outgoing bits
  logic [6:0] bits_ff; // bits presented so far
  logic is_read_ff; // frame is a read
  logic mdio_out_ff; // driven level
  logic oe_n_ff; // low while driving
  logic [15:0] rd_shift_ff; // incoming data bits
  logic take_ff; // capture request, one clock behind the mdc rise
  logic sync1_ff; // first synchroniser stage
  logic sync2_ff; // second synchroniser stage
  // decoded strobes
  logic [11:0] addr; // word aligned byte address
  logic acc; // first access cycle
  logic wr_take; // write commit edge
  logic port_ok; // port usable
  logic launch; // start of frame
  logic half_end; // counter at half period
  logic mdc_rise; // mdc going high
  logic mdc_fall; // mdc going low
  logic done; // frame complete
  logic [63:0] frame; // assembled frame

  assign addr = {paddr_in[11:2], 2'h0};
  assign acc = psel_in && penable_in && !pready_ff;
  assign wr_take = psel_in && penable_in && pready_ff && pwrite_in && !pslverr_ff;
  assign port_ok = port_on_ff && (div_ff != mdm_pkg::MDM_DIV_RST);
  assign launch = start_ff && ready_ff && port_ok &&
    (kind_ff == mdm_pkg::MDM_KIND_WRITE || kind_ff == mdm_pkg::MDM_KIND_READ);
  assign half_end = (state_ff == mdm_pkg::MDM_XFER) && (cnt_ff == div_act_ff);
  assign mdc_rise = half_end && !mdc_ff;
  assign mdc_fall = half_end && mdc_ff;
  assign done = mdc_fall && (bits_ff == mdm_pkg::MDM_FRAME_BITS);
  // payload was loaded by software before the command
  assign frame = {mdm_pkg::MDM_PREAMBLE, mdm_pkg::MDM_START, kind_ff, phy_ff, reg_ff,
    mdm_pkg::MDM_TA_WRITE, wpay_ff};

  // read mux and address decode
  always_comb
  begin
    rdata = 32'h00000000;
    mapped = 1'b1;
    if (addr == mdm_pkg::MDM_CFG_OFS)
    begin
      rdata[5:0] = div_ff;
      rdata[mdm_pkg::MDM_PORT_ON_BIT] = port_on_ff;
    end
    else if (addr == mdm_pkg::MDM_CMD_OFS)
    begin
      rdata[mdm_pkg::MDM_PHY_LSB +: 5] = phy_ff;
      rdata[mdm_pkg::MDM_REG_LSB +: 5] = reg_ff;
      rdata[mdm_pkg::MDM_KIND_LSB +: 2] = kind_ff;
      rdata[mdm_pkg::MDM_INIT_BIT] = start_ff;
      rdata[mdm_pkg::MDM_RDY_BIT] = ready_ff;
    end
    else if (addr == mdm_pkg::MDM_WPAY_OFS)
      rdata[15:0] = wpay_ff;
    else if (addr == mdm_pkg::MDM_RRES_OFS)
      rdata[15:0] = rres_ff;
    else if (addr == mdm_pkg::MDM_IST_OFS)
      rdata[mdm_pkg::MDM_IRQ_BIT] = ist_ff;
    else if (addr == mdm_pkg::MDM_IPEND_OFS)
      rdata[mdm_pkg::MDM_IRQ_BIT] = ist_ff && ien_ff;
    else if (addr == mdm_pkg::MDM_IEN_OFS)
      rdata[mdm_pkg::MDM_IRQ_BIT] = ien_ff;
    else if (addr == mdm_pkg::MDM_ICLR_OFS)
      rdata[mdm_pkg::MDM_IRQ_BIT] = iclr_ff;
    else
      mapped = 1'b0;
  end

  // apb answer: one wait state, data captured in the first access cycle
  always_ff @(posedge clk_sys_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff <= 32'h00000000;
    end
    else
    begin
      pready_ff <= acc;
      pslverr_ff <= acc && !mapped;
      if (acc)
        prdata_ff <= pwrite_in ? 32'h00000000 : rdata;
    end
  end

  // configuration: divider only reaches the engine at launch
  always_ff @(posedge clk_sys_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      div_ff <= mdm_pkg::MDM_DIV_RST;
      port_on_ff <= 1'b0;
    end
    else if (wr_take && addr == mdm_pkg::MDM_CFG_OFS)
    begin
      div_ff <= pwdata_in[5:0];
      port_on_ff <= pwdata_in[mdm_pkg::MDM_PORT_ON_BIT];
    end
  end

  // command fields, accepted at any time
  always_ff @(posedge clk_sys_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      phy_ff <= 5'h00;
      reg_ff <= 5'h00;
      kind_ff <= 2'h0;
    end
    else if (wr_take && addr == mdm_pkg::MDM_CMD_OFS)
    begin
      phy_ff <= pwdata_in[mdm_pkg::MDM_PHY_LSB +: 5];
      reg_ff <= pwdata_in[mdm_pkg::MDM_REG_LSB +: 5];
      kind_ff <= pwdata_in[mdm_pkg::MDM_KIND_LSB +: 2];
    end
  end

  // initiate: one-cycle request; lost if the engine is busy or disabled
  always_ff @(posedge clk_sys_in or posedge rst_in)
  begin
    if (rst_in)
      start_ff <= 1'b0;
    else
      start_ff <= wr_take && addr == mdm_pkg::MDM_CMD_OFS && pwdata_in[mdm_pkg::MDM_INIT_BIT];
  end

  // payload register
  always_ff @(posedge clk_sys_in or posedge rst_in)
  begin
    if (rst_in)
      wpay_ff <= mdm_pkg::MDM_DATA_RST;
    else if (wr_take && addr == mdm_pkg::MDM_WPAY_OFS)
      wpay_ff <= pwdata_in[15:0];
  end

  // read result: phy data wins over a software write
  always_ff @(posedge clk_sys_in or posedge rst_in)
  begin
    if (rst_in)
      rres_ff <= mdm_pkg::MDM_DATA_RST;
    else if (done && is_read_ff)
      rres_ff <= rd_shift_ff;
    else if (wr_take && addr == mdm_pkg::MDM_RRES_OFS)
      rres_ff <= pwdata_in[15:0];
  end

  // ready flag
  always_ff @(posedge clk_sys_in or posedge rst_in)
  begin
    if (rst_in)
      ready_ff <= mdm_pkg::MDM_RDY_RST;
    else if (launch)
      ready_ff <= 1'b0;
    else if (done)
      ready_ff <= 1'b1;
  end

  // interrupt status: hardware set wins over any clear
  always_ff @(posedge clk_sys_in or posedge rst_in)
  begin
    if (rst_in)
      ist_ff <= 1'b0;
    else if (done)
      ist_ff <= 1'b1;
    else if (wr_take && addr == mdm_pkg::MDM_IST_OFS)
      ist_ff <= pwdata_in[mdm_pkg::MDM_IRQ_BIT];
    else if (iclr_ff)
      ist_ff <= 1'b0;
  end

  // enable, clear pulse and interrupt line
  always_ff @(posedge clk_sys_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      ien_ff <= 1'b0;
      iclr_ff <= 1'b0;
      irq_ff <= 1'b0;
    end
    else
    begin
      if (wr_take && addr == mdm_pkg::MDM_IEN_OFS)
        ien_ff <= pwdata_in[mdm_pkg::MDM_IRQ_BIT];
      iclr_ff <= wr_take && addr == mdm_pkg::MDM_ICLR_OFS && pwdata_in[mdm_pkg::MDM_IRQ_BIT];
      irq_ff <= ist_ff && ien_ff;
    end
  end

  // mdc divider: idles low, toggles every div+1 host clocks
  always_ff @(posedge clk_sys_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      cnt_ff <= 6'h00;
      mdc_ff <= 1'b0;
    end
    else if (state_ff == mdm_pkg::MDM_IDLE)
    begin
      cnt_ff <= 6'h00;
      mdc_ff <= 1'b0;
    end
    else if (half_end)
    begin
      cnt_ff <= 6'h00;
      mdc_ff <= !mdc_ff;
    end
    else
      cnt_ff <= cnt_ff + 6'h01;
  end

  // mdio pin synchroniser
  always_ff @(posedge clk_sys_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      sync1_ff <= 1'b1;
      sync2_ff <= 1'b1;
    end
    else
    begin
      sync1_ff <= mdio_in;
      sync2_ff <= sync1_ff;
    end
  end

  // frame engine: bits change after mdc falls, sampled as mdc rises
  always_ff @(posedge clk_sys_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      state_ff <= mdm_pkg::MDM_IDLE;
      div_act_ff <= mdm_pkg::MDM_DIV_RST;
      shift_ff <= 64'h0000000000000000;
      bits_ff <= 7'h00;
      is_read_ff <= 1'b0;
      mdio_out_ff <= 1'b1;
      oe_n_ff <= 1'b1;
    end
    else
    begin
      case (state_ff)
        mdm_pkg::MDM_IDLE:
        begin
          if (launch)
          begin
            state_ff <= mdm_pkg::MDM_XFER;
            div_act_ff <= div_ff;
            shift_ff <= {frame[62:0], 1'b0};
            mdio_out_ff <= frame[63];
            oe_n_ff <= 1'b0;
            bits_ff <= 7'h01;
            is_read_ff <= kind_ff == mdm_pkg::MDM_KIND_READ;
          end
        end
        default:
        begin
          if (done)
          begin
            // line released between frames
            state_ff <= mdm_pkg::MDM_IDLE;
            oe_n_ff <= 1'b1;
            mdio_out_ff <= 1'b1;
          end
          else if (mdc_fall)
          begin
            mdio_out_ff <= shift_ff[63];
            shift_ff <= {shift_ff[62:0], 1'b0};
            bits_ff <= bits_ff + 7'h01;
            oe_n_ff <= is_read_ff && bits_ff >= mdm_pkg::MDM_DRIVE_BITS_READ;
          end
        end
      endcase
    end
  end

  // capture of read data, msb first; taken one clock after the mdc rise because
  // the synchroniser lags the pin, otherwise a divide of one samples the old bit
  always_ff @(posedge clk_sys_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      take_ff <= 1'b0;
      rd_shift_ff <= mdm_pkg::MDM_DATA_RST;
    end
    else
    begin
      take_ff <= mdc_rise && is_read_ff && bits_ff >= mdm_pkg::MDM_DATA_FIRST;
      if (take_ff)
        rd_shift_ff <= {rd_shift_ff[14:0], sync2_ff};
    end
  end

  assign prdata_out = prdata_ff;
  assign pready_out = pready_ff;
  assign pslverr_out = pslverr_ff;
  assign mdc_out = mdc_ff;
  assign mdio_out = mdio_out_ff;
  assign mdio_oe_n_out = oe_n_ff;
  assign irq_out = irq_ff;

  // checks
  busy_not_ready_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    state_ff == mdm_pkg::MDM_XFER |-> !ready_ff) else $error("ready high during frame");
  done_flags_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    done |=> ready_ff && ist_ff) else $error("completion did not set ready and status");
  div_zero_block_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    $rose(state_ff == mdm_pkg::MDM_XFER) |-> $past(div_ff) != 6'h00 && $past(port_on_ff))
    else $error("frame started with port disabled");
  mdc_period_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    $changed(mdc_ff) && state_ff == mdm_pkg::MDM_XFER |-> $past(cnt_ff) == div_act_ff)
    else $error("mdc toggled off the divider count");
  init_clear_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    start_ff |=> !start_ff) else $error("initiate bit stayed set");
  init_launch_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    start_ff && ready_ff && port_ok && kind_ff == mdm_pkg::MDM_KIND_WRITE |=> !ready_ff && !oe_n_ff)
    else $error("initiate did not start a write frame");
  wpay_upper_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    pready_ff && !pwrite_in && addr == mdm_pkg::MDM_WPAY_OFS |-> prdata_ff[31:16] == 16'h0000)
    else $error("payload upper bits not zero");
  rres_load_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    done && is_read_ff |=> rres_ff == $past(rd_shift_ff)) else $error("read data not stored");
  write_drive_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    state_ff == mdm_pkg::MDM_XFER && !is_read_ff |-> !oe_n_ff) else $error("write frame released line");
  sw_set_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    wr_take && addr == mdm_pkg::MDM_IST_OFS && pwdata_in[0] |=> ist_ff) else $error("status not set by write");
  irq_clear_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    iclr_ff && !done && !wr_take |=> !ist_ff && !iclr_ff) else $error("clear bit misbehaved");
  irq_line_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    ist_ff && ien_ff |=> irq_ff) else $error("interrupt line missing");
  write_frame_c: cover property (@(posedge clk_sys_in) disable iff (rst_in)
    launch && kind_ff == mdm_pkg::MDM_KIND_WRITE);
  read_frame_c: cover property (@(posedge clk_sys_in) disable iff (rst_in) done && is_read_ff);
  irq_raise_c: cover property (@(posedge clk_sys_in) disable iff (rst_in) $rose(irq_ff));
endmodule

// ### mdm_pkg.sv
// constants shared by the management host register block
package mdm_pkg;
  // register byte offsets
  localparam logic [11:0] MDM_CFG_OFS = 12'h500;
  localparam logic [11:0] MDM_CMD_OFS = 12'h504;
  localparam logic [11:0] MDM_WPAY_OFS = 12'h508;
  localparam logic [11:0] MDM_RRES_OFS = 12'h50c;
  localparam logic [11:0] MDM_IST_OFS = 12'h600;
  localparam logic [11:0] MDM_IPEND_OFS = 12'h620;
  localparam logic [11:0] MDM_IEN_OFS = 12'h640;
  localparam logic [11:0] MDM_ICLR_OFS = 12'h660;
  // field positions
  localparam int MDM_PHY_LSB = 24;
  localparam int MDM_REG_LSB = 16;
  localparam int MDM_KIND_LSB = 14;
  localparam int MDM_INIT_BIT = 11;
  localparam int MDM_RDY_BIT = 7;
  localparam int MDM_PORT_ON_BIT = 6;
  localparam int MDM_IRQ_BIT = 0;
  // access kind encodings
  localparam logic [1:0] MDM_KIND_WRITE = 2'h1;
  localparam logic [1:0] MDM_KIND_READ = 2'h2;
  // frame layout
  localparam logic [31:0] MDM_PREAMBLE = 32'hffffffff;
  localparam logic [1:0] MDM_START = 2'h1;
  localparam logic [1:0] MDM_TA_WRITE = 2'h2;
  localparam logic [6:0] MDM_FRAME_BITS = 7'h40;
  localparam logic [6:0] MDM_DRIVE_BITS_READ = 7'h2e;
  localparam logic [6:0] MDM_DATA_FIRST = 7'h31;
  // reset values
  localparam logic MDM_RDY_RST = 1'h1;
  localparam logic [5:0] MDM_DIV_RST = 6'h00;
  localparam logic [15:0] MDM_DATA_RST = 16'h0000;
  // engine states
  typedef enum logic [0:0] {MDM_IDLE = 1'b0, MDM_XFER = 1'b1} mdm_state_t;
endpackage

// ### mdm_phy_model.sv
// behavioural phy at the far end of the management link
`timescale 1ns/1ps
module mdm_phy_model #(
  parameter logic [4:0] PHY_ADDR = 5'h05
) (
  input wire logic mdc_in,
  input wire logic mdio_in,
  input wire logic oe_n_in,
  output logic drive_out,
  output logic bit_out,
  output logic [13:0] hdr_out
);
  logic [15:0] regs_ff [32]; // phy register file
  logic [31:0] sr_ff; // bits seen at mdc rises
  int cnt; // bits taken in the current frame
  logic rd; // frame is a read addressed to us
  assign rd = hdr_out[11:10] == 2'h2 && hdr_out[9:5] == PHY_ADDR;
  // known contents so that the bench can predict reads
  initial
  begin
    hdr_out = 14'h0;
    drive_out = 1'b0;
    cnt = 0;
    for (int i = 0; i < 32; i++) regs_ff[i] = 16'h1234 ^ (16'(i) * 16'h0101);
  end
  // sample on mdc rise; frame opens when the host drives the line
  always @(posedge mdc_in)
  begin
    if (cnt != 0 || !oe_n_in)
    begin
      sr_ff <= {sr_ff[30:0], mdio_in};
      cnt <= (cnt == 63) ? 0 : cnt + 1;
      if (cnt == 45) hdr_out <= {sr_ff[12:0], mdio_in};
      // only a write to our own address is stored
      if (cnt == 63 && hdr_out[11:10] == 2'h1 && hdr_out[9:5] == PHY_ADDR) regs_ff[hdr_out[4:0]] <= {sr_ff[14:0], mdio_in};
    end
  end
  // change on mdc fall: turnaround zero then data msb first
  always @(negedge mdc_in)
  begin
    drive_out <= rd && cnt >= 47 && cnt <= 63;
    bit_out <= (cnt == 47) ? 1'b0 : regs_ff[hdr_out[4:0]][4'(63 - cnt)];
  end
endmodule

// ### tb.sv
// self-checking bench for the management host register block
`timescale 1ns/1ps
module tb;
  logic clk_sys_in = 1'b0;
  logic rst_in = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, q;
  logic pready, pslverr, mdc, mdio_o, mdio_oe_n, irq, drv, pbit, mdio_w, err;
  logic [13:0] hdr; // header bits seen by the phy
  logic [15:0] mirror [32]; // predicted phy contents
  logic [1:0] kind;
  logic [4:0] r, p;
  logic [15:0] d;
  int failures = 0;
  int cmp_count = 0;
  always #10 clk_sys_in = ~clk_sys_in;
  // pull-up wins when nobody drives the line
  assign mdio_w = !mdio_oe_n ? mdio_o : (drv ? pbit : 1'b1);
  mdm_mgmt_host uut (.clk_sys_in(clk_sys_in), .rst_in(rst_in), .psel_in(psel), .penable_in(penable),
    .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready),
    .pslverr_out(pslverr), .mdc_out(mdc), .mdio_out(mdio_o), .mdio_oe_n_out(mdio_oe_n), .mdio_in(mdio_w),
    .irq_out(irq));
  mdm_phy_model phy (.mdc_in(mdc), .mdio_in(mdio_w), .oe_n_in(mdio_oe_n), .drive_out(drv), .bit_out(pbit),
    .hdr_out(hdr));
  // expected command word readback
  function automatic logic [31:0] cmdw(input logic [1:0] k, input logic [4:0] a, input logic [4:0] g,
    input logic rdy);
    return {3'h0, a, 3'h0, g, k, 2'h0, 1'b0, 3'h0, rdy, 7'h0};
  endfunction
  task automatic finish_test;
    if (failures == 0 && cmp_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      failures++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // one apb transfer; held until pready seen at an edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk_sys_in);
    penable <= 1'b1;
    do
    begin
      @(posedge clk_sys_in);
    end
    while (pready !== 1'b1);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // idle edge so no signal is set twice in one step
    @(posedge clk_sys_in);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(q, exp);
  endtask
  task automatic go(input logic [1:0] k, input logic [4:0] a, input logic [4:0] g);
    apb(1'b1, mdm_pkg::MDM_CMD_OFS, {3'h0, a, 3'h0, g, k, 2'h0, 1'b1, 11'h0});
  endtask
  // main sequence
  initial
  begin
    void'($urandom(25));
    for (int i = 0; i < 32; i++) mirror[i] = 16'h1234 ^ (16'(i) * 16'h0101);
    repeat (3) @(posedge clk_sys_in);
    rst_in <= 1'b0;
    @(posedge clk_sys_in);
    rd(mdm_pkg::MDM_CMD_OFS, 32'h80);
    rd(mdm_pkg::MDM_WPAY_OFS, 32'h0);
    rd(mdm_pkg::MDM_RRES_OFS, 32'h0);
    rd(mdm_pkg::MDM_IST_OFS, 32'h0);
    rd(12'h704, 32'h0);
    chk({31'h0, err}, 32'h1);
    // port on but divide zero: launch must be dropped
    apb(1'b1, mdm_pkg::MDM_CFG_OFS, 32'h40);
    go(mdm_pkg::MDM_KIND_READ, 5'h05, 5'h03);
    repeat (8) @(posedge clk_sys_in);
    chk({31'h0, mdio_oe_n}, 32'h1);
    rd(mdm_pkg::MDM_CMD_OFS, cmdw(mdm_pkg::MDM_KIND_READ, 5'h05, 5'h03, 1'b1));
    apb(1'b1, mdm_pkg::MDM_CFG_OFS, 32'h41);
    apb(1'b1, mdm_pkg::MDM_IEN_OFS, 32'h1);
    // illegal access kinds never launch
    for (int k = 0; k < 4; k += 3)
    begin
      go(2'(k), 5'h05, 5'h01);
      rd(mdm_pkg::MDM_CMD_OFS, cmdw(2'(k), 5'h05, 5'h01, 1'b1));
    end
    // write then read back, last read to an absent phy
    for (int i = 0; i < 8; i++)
    begin
      kind = (i % 2 == 0) ? mdm_pkg::MDM_KIND_WRITE : mdm_pkg::MDM_KIND_READ;
      if (i % 2 == 0)
      begin
        r = 5'($urandom);
        d = 16'($urandom);
        mirror[r] = d;
        apb(1'b1, mdm_pkg::MDM_WPAY_OFS, {~d, d});
        rd(mdm_pkg::MDM_WPAY_OFS, {16'h0, d});
      end
      p = (i == 7) ? 5'h06 : 5'h05;
      go(kind, p, r);
      // initiate while busy is dropped but its fields are taken, so put them back
      if (i == 1)
      begin
        go(mdm_pkg::MDM_KIND_WRITE, p, r + 5'h1);
        rd(mdm_pkg::MDM_CMD_OFS, cmdw(mdm_pkg::MDM_KIND_WRITE, p, r + 5'h1, 1'b0));
        apb(1'b1, mdm_pkg::MDM_CMD_OFS, cmdw(kind, p, r, 1'b0));
      end
      rd(mdm_pkg::MDM_CMD_OFS, cmdw(kind, p, r, 1'b0));
      for (int n = 0; n < 4000 && irq !== 1'b1; n++) @(posedge clk_sys_in);
      chk({31'h0, irq}, 32'h1);
      chk({18'h0, hdr}, {18'h0, 2'h1, kind, p, r});
      rd(mdm_pkg::MDM_CMD_OFS, cmdw(kind, p, r, 1'b1));
      rd(mdm_pkg::MDM_IST_OFS, 32'h1);
      if (i % 2 == 1) rd(mdm_pkg::MDM_RRES_OFS, {16'h0, (p == 5'h05) ? mirror[r] : 16'hffff});
      if (i % 4 < 2)
        apb(1'b1, mdm_pkg::MDM_ICLR_OFS, 32'h1);
      else
        apb(1'b1, mdm_pkg::MDM_IST_OFS, 32'h0);
      rd(mdm_pkg::MDM_IST_OFS, 32'h0);
      chk({31'h0, irq}, 32'h0);
    end
    // software set, then mask
    apb(1'b1, mdm_pkg::MDM_IST_OFS, 32'h1);
    rd(mdm_pkg::MDM_IST_OFS, 32'h1);
    rd(mdm_pkg::MDM_IPEND_OFS, 32'h1);
    chk({31'h0, irq}, 32'h1);
    apb(1'b1, mdm_pkg::MDM_IEN_OFS, 32'h0);
    rd(mdm_pkg::MDM_IPEND_OFS, 32'h0);
    chk({31'h0, irq}, 32'h0);
    finish_test;
  end
  // watchdog well beyond ten frames
  initial
  begin
    repeat (40000) @(posedge clk_sys_in);
    failures++;
    finish_test;
  end
endmodule
